// ---- hw/rdc_regs.sv ----
// Purpose: Control register bank of a dual-lane linear redriver
// Assumes: A register-port agent (I2C slave) gives single-cycle byte strobes
// Notes: Pin inputs pass a three-stage synchroniser before use
`timescale 1ns/1ns
`include "rdc_params.svh"

// Operation
// - Link enable codes 1 and 3 enable the USB path, 0 and 2 disable it.
// - Orientation bit 0 selects normal, 1 selects flipped orientation.
// - Register-source bit 0 takes EQ from sampled pins, 1 from programmed registers.
// - Output limit bit 0 gives linear mode, 1 gives limited mode.
// - Top two shaping bits pick pre-cursor 1.5, 2, 2.3 or 2.8 dB.
// - Pre-cursor applies only when enabled and in limited mode, else 0 dB.
// - Bits 4-3 pick post-cursor -1.5, -2.1, -3.2 or -3.8 dB.
// - De-emphasis applies only when enabled and in limited mode, else 0 dB.
// - Lane 2 has its own shaping register with the same layout.
// - Four-bit adaptive upper bound, reset 8, caps the full algorithm's search.
// - On electrical idle, select bit 0 enters U1 and 1 enters U3.
// - Algorithm select 0 fast, 1 full every, 2 full II, 3 full first; reset 2.
// - Adaptive enable bit turns connector receiver adaptation on; reset 1.
// - Without adaptation or register source, connector EQ reads back the sampled pins.
module rdc_regs
  import rdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [1:0] connector_eq_pins,
  output logic usb_path_en,
  output logic flip_orientation,
  output logic eq_from_registers,
  output logic limited_mode,
  output rdc_lane_cfg_t system_tx_lane1,
  output rdc_lane_cfg_t system_tx_lane2,
  output logic [3:0] adapt_max_setting,
  output rdc_alg_t adapt_algorithm_sel,
  output rdc_idle_t idle_deep_state_sel,
  output logic adapt_eq_enable,
  output logic [1:0] connector_eq_sampled,
  output logic pins_as_eq_source
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] masked_write(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic [7:0] mask);
    masked_write = (new_v & mask) | (old_v & ~mask);
  endfunction

  function automatic rdc_lane_cfg_t lane_apply(input rdc_shaping_t s, input logic lim);
    lane_apply.precursor_on = s.precursor_en & lim;
    lane_apply.precursor_code = s.precursor_level;
    lane_apply.postcursor_on = s.postcursor_en & lim;
    lane_apply.postcursor_code = s.postcursor_level;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_val_ff;
  logic [1:0] nxt_pin_val;

  always_comb begin
    // A change counts only once the last two stages agree
    nxt_pin_val = (pin_s2_ff == pin_s3_ff) ? pin_s3_ff : pin_val_ff;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= 2'h0;
      pin_s2_ff <= 2'h0;
      pin_s3_ff <= 2'h0;
      pin_val_ff <= 2'h0;
    end else begin
      pin_s1_ff <= connector_eq_pins;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_val_ff <= nxt_pin_val;
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  rdc_general_t gen_ff, nxt_gen;
  rdc_shaping_t tx1_ff, nxt_tx1;
  rdc_shaping_t tx2_ff, nxt_tx2;
  rdc_adapt_t aeq_ff, nxt_aeq;
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;

  always_comb begin
    nxt_gen = gen_ff;
    nxt_tx1 = tx1_ff;
    nxt_tx2 = tx2_ff;
    nxt_aeq = aeq_ff;
    if (reg_wr_stb) begin
      case (reg_addr)
        `RDC_OFS_GENERAL_CONTROL: begin
          // Reserved bits 6,5,3 held at reset value
          nxt_gen = masked_write(gen_ff, reg_wdata, `RDC_GC_WR_MASK);
        end
        `RDC_OFS_TX_LANE1_SHAPING: begin
          // Lane 1 low bits are writable reserved storage
          nxt_tx1 = masked_write(tx1_ff, reg_wdata, `RDC_TX1_WR_MASK);
        end
        `RDC_OFS_TX_LANE2_SHAPING: begin
          nxt_tx2 = masked_write(tx2_ff, reg_wdata, `RDC_TX2_WR_MASK);
        end
        `RDC_OFS_ADAPTIVE_EQ_CONTROL: begin
          nxt_aeq = masked_write(aeq_ff, reg_wdata, `RDC_AEQ_WR_MASK);
        end
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
  end

  always_comb begin
    nxt_rvalid = reg_rd_stb;
    nxt_rdata = rdata_ff;
    if (reg_rd_stb) begin
      case (reg_addr)
        `RDC_OFS_GENERAL_CONTROL: nxt_rdata = gen_ff;
        `RDC_OFS_TX_LANE1_SHAPING: nxt_rdata = tx1_ff;
        `RDC_OFS_TX_LANE2_SHAPING: nxt_rdata = tx2_ff;
        `RDC_OFS_ADAPTIVE_EQ_CONTROL: nxt_rdata = aeq_ff;
        default: nxt_rdata = `RDC_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_ff <= `RDC_RST_GENERAL_CONTROL;
      tx1_ff <= `RDC_RST_TX_LANE1_SHAPING;
      tx2_ff <= `RDC_RST_TX_LANE2_SHAPING;
      aeq_ff <= `RDC_RST_ADAPTIVE_EQ_CONTROL;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      gen_ff <= nxt_gen;
      tx1_ff <= nxt_tx1;
      tx2_ff <= nxt_tx2;
      aeq_ff <= nxt_aeq;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic usb_en_ff, flip_ff, eqreg_ff, lim_ff, adapt_en_ff, pin_src_ff;
  logic [3:0] max_ff;
  rdc_alg_t alg_ff;
  rdc_idle_t idle_ff;
  rdc_lane_cfg_t lane1_ff, lane2_ff;
  logic [1:0] ceq_ff;
  logic nxt_usb_en, nxt_pin_src;
  logic nxt_flip, nxt_eqreg, nxt_lim, nxt_adapt_en;
  logic [3:0] nxt_max;
  rdc_alg_t nxt_alg;
  rdc_idle_t nxt_idle;
  rdc_lane_cfg_t nxt_lane1, nxt_lane2;
  logic [1:0] nxt_ceq;

  // ----------------------------------------------------------------
  // Decode of the stored bytes
  // ----------------------------------------------------------------
  // Outputs trail the register by one edge so every control changes
  // together from flops, never through a glitching decode.
  always_comb begin
    // Odd codes enable the path
    nxt_usb_en = gen_ff.link_enable_code[0];
    nxt_flip = gen_ff.flip_orientation;
    nxt_eqreg = gen_ff.eq_source_register_sel;
    nxt_lim = gen_ff.output_limit_mode_en;
    // Codes pass through as written; the on flags carry the limit gate
    nxt_lane1 = lane_apply(tx1_ff, gen_ff.output_limit_mode_en);
    nxt_lane2 = lane_apply(tx2_ff, gen_ff.output_limit_mode_en);
    nxt_max = aeq_ff.adapt_max_setting;
    nxt_alg = rdc_alg_t'(aeq_ff.adapt_algorithm_sel);
    nxt_idle = rdc_idle_t'(aeq_ff.idle_deep_state_sel);
    nxt_adapt_en = aeq_ff.adapt_eq_enable;
    nxt_ceq = pin_val_ff;
    // Pins drive receiver EQ only with adaptation off and no register source
    nxt_pin_src = ~aeq_ff.adapt_eq_enable & ~gen_ff.eq_source_register_sel;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usb_en_ff <= 1'b0;
      flip_ff <= 1'b0;
      eqreg_ff <= 1'b0;
      lim_ff <= 1'b0;
      lane1_ff <= '0;
      lane2_ff <= '0;
      max_ff <= 4'h8;
      alg_ff <= RDC_ALG_FULL_II;
      idle_ff <= RDC_IDLE_U1;
      adapt_en_ff <= 1'b1;
      ceq_ff <= 2'h0;
      pin_src_ff <= 1'b0;
    end else begin
      usb_en_ff <= nxt_usb_en;
      flip_ff <= nxt_flip;
      eqreg_ff <= nxt_eqreg;
      lim_ff <= nxt_lim;
      lane1_ff <= nxt_lane1;
      lane2_ff <= nxt_lane2;
      max_ff <= nxt_max;
      alg_ff <= nxt_alg;
      idle_ff <= nxt_idle;
      adapt_en_ff <= nxt_adapt_en;
      ceq_ff <= nxt_ceq;
      pin_src_ff <= nxt_pin_src;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign usb_path_en = usb_en_ff;
  assign flip_orientation = flip_ff;
  assign eq_from_registers = eqreg_ff;
  assign limited_mode = lim_ff;
  assign system_tx_lane1 = lane1_ff;
  assign system_tx_lane2 = lane2_ff;
  assign adapt_max_setting = max_ff;
  assign adapt_algorithm_sel = alg_ff;
  assign idle_deep_state_sel = idle_ff;
  assign adapt_eq_enable = adapt_en_ff;
  assign connector_eq_sampled = ceq_ff;
  assign pins_as_eq_source = pin_src_ff;

endmodule

// ---- common/rdc_params.svh ----
// Purpose: Offsets, write masks and reset values of the redriver control bank
// Assumes: Byte-wide registers behind the device's register port
// Notes: Definitions only
`ifndef RDC_PARAMS_SVH
`define RDC_PARAMS_SVH
`define RDC_OFS_GENERAL_CONTROL 8'h0a
`define RDC_OFS_TX_LANE1_SHAPING 8'h0b
`define RDC_OFS_TX_LANE2_SHAPING 8'h0c
`define RDC_OFS_ADAPTIVE_EQ_CONTROL 8'h1c
`define RDC_RST_GENERAL_CONTROL 8'h00
`define RDC_RST_TX_LANE1_SHAPING 8'h6f
`define RDC_RST_TX_LANE2_SHAPING 8'h6c
`define RDC_RST_ADAPTIVE_EQ_CONTROL 8'h85
`define RDC_GC_WR_MASK 8'h97
`define RDC_TX1_WR_MASK 8'hff
`define RDC_TX2_WR_MASK 8'hfc
`define RDC_AEQ_WR_MASK 8'hff
`define RDC_UNMAPPED_READ 8'h00
`endif

// ---- common/rdc_pkg.sv ----
// Purpose: Types for the redriver control bank
// Assumes: Field layouts match rdc_params.svh
// Notes: Packed MSB first so a byte casts straight onto its fields
package rdc_pkg;
  typedef struct packed {
    logic output_limit_mode_en;
    logic [1:0] rsvd_hi;
    logic eq_source_register_sel;
    logic rsvd_mid;
    logic flip_orientation;
    logic [1:0] link_enable_code;
  } rdc_general_t;
  typedef struct packed {
    logic [1:0] precursor_level;
    logic precursor_en;
    logic [1:0] postcursor_level;
    logic postcursor_en;
    logic [1:0] rsvd;
  } rdc_shaping_t;
  typedef struct packed {
    logic [3:0] adapt_max_setting;
    logic idle_deep_state_sel;
    logic [1:0] adapt_algorithm_sel;
    logic adapt_eq_enable;
  } rdc_adapt_t;
  typedef enum logic [1:0] {
    RDC_ALG_FAST, RDC_ALG_FULL_EVERY, RDC_ALG_FULL_II, RDC_ALG_FULL_FIRST
  } rdc_alg_t;
  typedef enum logic {RDC_IDLE_U1, RDC_IDLE_U3} rdc_idle_t;
  // Applied lane shaping: codes stay as written, enables say whether they count
  typedef struct packed {
    logic precursor_on;
    logic [1:0] precursor_code;
    logic postcursor_on;
    logic [1:0] postcursor_code;
  } rdc_lane_cfg_t;
endpackage

// ---- sim/rdc_regs_assertions.sv ----
// Purpose: Port-level properties of the redriver control bank
// Assumes: Bound to rdc_regs; one clock domain
// Notes: Decoded outputs lag a write strobe by two edges
`timescale 1ns/1ns
module rdc_regs_assertions
  import rdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic usb_path_en,
  input wire logic eq_from_registers,
  input wire logic limited_mode,
  input wire rdc_lane_cfg_t system_tx_lane1,
  input wire rdc_lane_cfg_t system_tx_lane2,
  input wire logic [3:0] adapt_max_setting,
  input wire logic adapt_eq_enable,
  input wire logic pins_as_eq_source
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic g_w = reg_wr_stb && reg_addr == 8'h0a;
  wire logic a_w = reg_wr_stb && reg_addr == 8'h1c;
  property p_rv; 1 |=> reg_rvalid == $past(reg_rd_stb); endproperty
  a_rv: assert property (p_rv) else $error("read valid off");
  property p_usb; g_w |=> ##1 usb_path_en == $past(reg_wdata[0], 2); endproperty
  a_usb: assert property (p_usb) else $error("link enable wrong");
  property p_src; g_w |=> ##1 eq_from_registers == $past(reg_wdata[4], 2); endproperty
  a_src: assert property (p_src) else $error("eq source wrong");
  property p_lim; g_w |=> ##1 limited_mode == $past(reg_wdata[7], 2); endproperty
  a_lim: assert property (p_lim) else $error("limit mode wrong");
  property p_pre; system_tx_lane1.precursor_on |-> limited_mode; endproperty
  a_pre: assert property (p_pre) else $error("precursor outside limit mode");
  property p_post; system_tx_lane2.postcursor_on |-> limited_mode; endproperty
  a_post: assert property (p_post) else $error("postcursor outside limit mode");
  property p_max; a_w |=> ##1 adapt_max_setting == $past(reg_wdata[7:4], 2); endproperty
  a_max: assert property (p_max) else $error("upper bound wrong");
  property p_aen; a_w |=> ##1 adapt_eq_enable == $past(reg_wdata[0], 2); endproperty
  a_aen: assert property (p_aen) else $error("adapt enable wrong");
  property p_pin; pins_as_eq_source == (!adapt_eq_enable && !eq_from_registers); endproperty
  a_pin: assert property (p_pin) else $error("pin source wrong");
  property p_rsv; reg_rd_stb && reg_addr == 8'h0c |=> reg_rdata[1:0] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule
bind rdc_regs rdc_regs_assertions u_rdc_chk (.*);

// ---- sim/rdc_host_model.sv ----
// Purpose: Register-port agent standing in for the host controller
// Assumes: Strobes are taken on the rising clock edge
// Notes: Released address and data are inverted so stale values never match
`timescale 1ns/1ns
module rdc_host_model (
  input wire logic clk,
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [7:0] wd,
  input wire logic [7:0] rdata,
  input wire logic rv
);
  initial begin
    wr = 1'h0;
    rd = 1'h0;
    addr = 8'h00;
    wd = 8'h00;
  end
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'h0;
    addr <= ~a;
    wd <= ~d;
  endtask
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    addr <= ~a;
    #1 d = (rv === 1'h1) ? rdata : 8'hxx;
  endtask
endmodule

// ---- sim/rdc_regs_tb.sv ----
// Purpose: Self-checking bench for the redriver control bank
// Assumes: Host agent drives strobes; bench drives the strap pins
// Notes: Reference model keeps the four bytes as ints with write masks
`timescale 1ns/1ns
module rdc_regs_tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [1:0] pins = 2'h0;
  wire logic wr, rd, rv;
  wire logic [7:0] addr, wd, rdata;
  wire logic [26:0] o;
  logic [26:0] e;
  logic [7:0] d;
  logic [15:0] lf = 16'h0002;
  int m[4] = '{'h00, 'h6f, 'h6c, 'h85};
  int msk[4] = '{'h97, 'hff, 'hfc, 'hff};
  int ofs[5] = '{'h0a, 'h0b, 'h0c, 'h1c, 'h1d};
  int errors = 0, num_checks = 0, cyc = 0, i;
  always #20 clk = ~clk;
  rdc_host_model h (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wd(wd), .rdata(rdata), .rv(rv));
  rdc_regs dut (.clk(clk), .rst_n(rst_n), .reg_wr_stb(wr), .reg_rd_stb(rd), .reg_addr(addr),
    .reg_wdata(wd), .reg_rdata(rdata), .reg_rvalid(rv), .connector_eq_pins(pins),
    .usb_path_en(o[26]), .flip_orientation(o[25]), .eq_from_registers(o[24]),
    .limited_mode(o[23]), .system_tx_lane1(o[22:17]), .system_tx_lane2(o[16:11]),
    .adapt_max_setting(o[10:7]), .adapt_algorithm_sel(o[6:5]), .idle_deep_state_sel(o[4]),
    .adapt_eq_enable(o[3]), .connector_eq_sampled(o[2:1]), .pins_as_eq_source(o[0]));
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Shaping only counts in limit mode, so each enable is gated by bit 7
  function automatic logic [26:0] ex();
    logic [7:0] g, t, u, a;
    g = m[0][7:0];
    t = m[1][7:0];
    u = m[2][7:0];
    a = m[3][7:0];
    return {g[0], g[2], g[4], g[7], t[5] & g[7], t[7:6], t[2] & g[7], t[4:3], u[5] & g[7],
      u[7:6], u[2] & g[7], u[4:3], a[7:4], a[2:1], a[3], a[0], pins, ~a[0] & ~g[4]};
  endfunction
  task automatic chk(input logic [26:0] s, input logic [26:0] x);
    num_checks++;
    if (s !== x) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    // Decoded outputs settle from the stored bytes one edge after release
    repeat (2) @(posedge clk);
    #1 chk(o, ex());
    for (i = 0; i < 5; i++) begin
      h.rd_byte(ofs[i][7:0], d);
      chk(27'(d), 27'(i < 4 ? m[i] : 0));
    end
    $display("Test reset values done");
    repeat (60) begin
      lf = nx(lf);
      i = lf[7:0] % 5;
      h.wr_byte(ofs[i][7:0], lf[15:8]);
      if (i < 4) m[i] = (m[i] & ~msk[i]) | (lf[15:8] & msk[i]);
      pins <= lf[9:8];
      repeat (6) @(posedge clk);
      #1 e = ex();
      chk(o[26:11], e[26:11]);
      chk(o[10:0], e[10:0]);
      h.rd_byte(ofs[i][7:0], d);
      chk(27'(d), 27'(i < 4 ? m[i] : 0));
    end
    $display("Test random traffic done");
    end_sim();
  end
endmodule
